/* tb/pfg_board.sv */
`timescale 1ns/10ps

// Board side of the flag pins: device drive wins where enabled
module pfg_board (
  input wire logic [15:0] pin_out_in,
  input wire logic [15:0] oe_n_in,
  input wire logic [15:0] ext_in,
  output logic [15:0] pin_in_out
);
  always_comb
  begin
    pin_in_out = (pin_out_in & ~oe_n_in) | (ext_in & oe_n_in);
  end
endmodule : pfg_board

/* tb/tb_top.sv */
`timescale 1ns/10ps
`include "pfg_params.svh"

module tb_top
  import pfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n;
  pfg_bus_req_t req;
  pfg_word_t rdo, pin, pout, oen, ext, fs;
  logic wide, uoe_n, irq, sirq;
  logic [7:0] ud, udo;
  int fails = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  pfg_gpio u_dut (
    .sys_clk_in(clk),
    .rst_n_in(rst_n),
    .bus_req_in(req),
    .rd_data_out(rdo),
    .pin_in(pin),
    .pin_out(pout),
    .pin_oe_n_out(oen),
    .bus_wide_in(wide),
    .upper_data_lines_in(ud),
    .upper_data_lines_oe_n_in(uoe_n),
    .upper_data_lines_out(udo),
    .flag_status_out(fs),
    .irq_out(irq),
    .soft_irq_out(sirq)
  );

  pfg_board u_board (
    .pin_out_in(pout),
    .oe_n_in(oen),
    .ext_in(ext),
    .pin_in_out(pin)
  );

  ////////////////////////////////////////////////////////////////////
  task chk(input pfg_word_t got, input pfg_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Strobe stays up until the next task overwrites it: no double drive
  task wr(input logic [3:0] a, input pfg_word_t d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask : wr

  task nap(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask : nap

  // Data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input pfg_word_t e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    chk(rdo, e);
  endtask : rd

  task summarize;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    ext = '0;
    wide = 1'b0;
    uoe_n = 1'b1;
    ud = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 11; a++) rd(a[3:0], 16'h0000);
    chk(oen, 16'hffff);
    wr(`PFG_OFS_DIR, 16'h00ff);
    wr(`PFG_OFS_VSET, 16'h00a5);
    wr(`PFG_OFS_VCLR, 16'h0005);
    nap(3);
    chk(oen, 16'hff00);
    chk(pout, 16'h00a0);
    rd(`PFG_OFS_VSET, 16'h00a0);
    wr(`PFG_OFS_POL, 16'h0200);
    wr(`PFG_OFS_SENSE, 16'h0300);
    wr(`PFG_OFS_MSK, 16'h0301);
    wr(`PFG_OFS_IESET, 16'h0301);
    ext <= 16'h0100;
    nap(4);
    chk(fs, 16'h01a0);
    chk({15'h0000, irq}, 16'h0001);
    rd(`PFG_OFS_STS, 16'h0100);
    wr(`PFG_OFS_STS, 16'h0100);
    nap(2);
    chk({15'h0000, irq}, 16'h0000);
    ext <= 16'h0000;
    nap(4);
    chk({15'h0000, irq}, 16'h0000);
    wr(`PFG_OFS_EDGE, 16'h0100);
    ext <= 16'h0100;
    nap(4);
    wr(`PFG_OFS_STS, 16'h0100);
    nap(2);
    chk({15'h0000, irq}, 16'h0000);
    ext <= 16'h0000;
    nap(4);
    chk({15'h0000, irq}, 16'h0001);
    wr(`PFG_OFS_STS, 16'h0100);
    ext <= 16'h0200;
    nap(4);
    chk({15'h0000, irq}, 16'h0000);
    ext <= 16'h0000;
    nap(4);
    chk({15'h0000, irq}, 16'h0001);
    rd(`PFG_OFS_STS, 16'h0200);
    wr(`PFG_OFS_STS, 16'h0200);
    wr(`PFG_OFS_IECLR, 16'h0300);
    wr(`PFG_OFS_IESET, 16'h0002);
    rd(`PFG_OFS_IESET, 16'h0003);
    ext <= 16'h0100;
    nap(4);
    chk({15'h0000, irq}, 16'h0000);
    wr(`PFG_OFS_VSET, 16'h0001);
    nap(4);
    chk({15'h0000, sirq}, 16'h0001);
    wr(`PFG_OFS_STS, 16'h0001);
    nap(2);
    chk({15'h0000, sirq}, 16'h0001);
    wr(`PFG_OFS_VCLR, 16'h0001);
    wr(`PFG_OFS_STS, 16'h0001);
    nap(3);
    chk({15'h0000, sirq}, 16'h0000);
    // Active low level on a driven-low output pin
    wr(`PFG_OFS_POL, 16'h0201);
    nap(2);
    chk({15'h0000, sirq}, 16'h0001);
    wr(`PFG_OFS_POL, 16'h0200);
    wr(`PFG_OFS_STS, 16'h0001);
    nap(2);
    chk({15'h0000, sirq}, 16'h0000);
    wide <= 1'b1;
    uoe_n <= 1'b0;
    ud <= 8'h5a;
    // Pin loop back passes the two sync stages again
    nap(6);
    chk(oen, 16'h0000);
    chk(pout, 16'h5aa0);
    chk({8'h00, udo}, 16'h005a);
    wr(`PFG_OFS_VSET, 16'h0002);
    nap(3);
    chk(pout, 16'h5aa2);
    // Edge on a pin lent to the data bus must not raise status
    wr(`PFG_OFS_IESET, 16'h0100);
    ud <= 8'h5b;
    nap(6);
    rd(`PFG_OFS_STS, 16'h0002);
    summarize();
  end
endmodule : tb_top

/* verilog/pfg_gpio.sv */
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "pfg_params.svh"

module pfg_gpio
  import pfg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire pfg_bus_req_t bus_req_in,
  output logic [`PFG_NPINS-1:0] rd_data_out,
  input wire logic [`PFG_NPINS-1:0] pin_in,
  output logic [`PFG_NPINS-1:0] pin_out,
  output logic [`PFG_NPINS-1:0] pin_oe_n_out,
  input wire logic bus_wide_in,
  input wire logic [7:0] upper_data_lines_in,
  input wire logic upper_data_lines_oe_n_in,
  output logic [7:0] upper_data_lines_out,
  output logic [`PFG_NPINS-1:0] flag_status_out,
  output logic irq_out,
  output logic soft_irq_out
);

  localparam pfg_state_t ST_RST = '{
    dir: `PFG_RST_DIR,
    outv: `PFG_RST_OUTV,
    ien: `PFG_RST_IEN,
    pol: `PFG_RST_POL,
    sense: `PFG_RST_SENSE,
    edge_sel: `PFG_RST_EDGE,
    sts: `PFG_RST_STS,
    msk: `PFG_RST_MSK,
    pin_oe_n: `PFG_RST_OE_N,
    default: '0
  };

  pfg_state_t st_q;
  pfg_state_t st_d;
  pfg_word_t src;
  pfg_word_t act;
  pfg_word_t evt;
  pfg_word_t gpio_pins;

  ////////////////////////////////////////////////////////////////////////
  // Event detection

  // Upper pins leave flag duty on a wide bus
  assign gpio_pins = st_q.wide2 ? `PFG_LOW_PINS : '1;

  // Outputs feed their own value back, so software can raise an irq
  assign src = (st_q.dir & st_q.outv) | (~st_q.dir & st_q.sync2);
  assign act = src ^ st_q.pol;

  generate
    for (genvar i = 0; i < `PFG_NPINS; i++)
    begin : g_pin
      logic rise;
      logic fall;
      assign rise = act[i] & ~st_q.prev[i];
      assign fall = ~act[i] & st_q.prev[i];
      // Level pins re-set status while held active
      assign evt[i] = gpio_pins[i] & st_q.ien[i] &
        (st_q.sense[i] ? (rise | (st_q.edge_sel[i] & fall))
                       : act[i]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    pfg_word_t rmux;
    rmux = '0;
    st_d = st_q;
    // Two stages before anything looks at pins or strap
    st_d.sync1 = pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.wide1 = bus_wide_in;
    st_d.wide2 = st_q.wide1;
    st_d.prev = act;
    st_d.flags = src;
    // New events win over a clear in the same cycle
    st_d.sts = st_q.sts | evt;
    st_d.rdata = '0;
    if (bus_req_in.wr)
    begin
      unique case (bus_req_in.addr)
        `PFG_OFS_DIR: st_d.dir = bus_req_in.wdata;
        `PFG_OFS_VSET: st_d.outv = st_q.outv | bus_req_in.wdata;
        `PFG_OFS_VCLR: st_d.outv = st_q.outv & ~bus_req_in.wdata;
        `PFG_OFS_IESET: st_d.ien = st_q.ien | bus_req_in.wdata;
        `PFG_OFS_IECLR: st_d.ien = st_q.ien & ~bus_req_in.wdata;
        `PFG_OFS_POL: st_d.pol = bus_req_in.wdata;
        `PFG_OFS_SENSE: st_d.sense = bus_req_in.wdata;
        `PFG_OFS_EDGE: st_d.edge_sel = bus_req_in.wdata;
        `PFG_OFS_STS: st_d.sts = (st_q.sts & ~bus_req_in.wdata) | evt;
        `PFG_OFS_MSK: st_d.msk = bus_req_in.wdata;
        default: ;
      endcase
    end
    if (bus_req_in.rd)
    begin
      unique case (bus_req_in.addr)
        `PFG_OFS_DIR: rmux = st_q.dir;
        `PFG_OFS_VSET: rmux = st_q.flags;
        `PFG_OFS_VCLR: rmux = st_q.flags;
        `PFG_OFS_IESET: rmux = st_q.ien;
        `PFG_OFS_IECLR: rmux = st_q.ien;
        `PFG_OFS_POL: rmux = st_q.pol;
        `PFG_OFS_SENSE: rmux = st_q.sense;
        `PFG_OFS_EDGE: rmux = st_q.edge_sel;
        `PFG_OFS_STS: rmux = st_q.sts;
        `PFG_OFS_MSK: rmux = st_q.msk;
        default: rmux = '0;
      endcase
      st_d.rdata = rmux;
    end
    // Pin drivers; upper byte handed to the external data bus when wide
    st_d.pin_o = st_q.outv;
    st_d.pin_oe_n = ~st_q.dir;
    if (st_q.wide2)
    begin
      st_d.pin_o[15:8] = upper_data_lines_in;
      st_d.pin_oe_n[15:8] = {8{upper_data_lines_oe_n_in}};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data_out = st_q.rdata;
  assign pin_out = st_q.pin_o;
  assign pin_oe_n_out = st_q.pin_oe_n;
  assign upper_data_lines_out = st_q.sync2[15:8];
  assign flag_status_out = st_q.flags;
  // Input-pin sources go to the hardware line, output pins to software
  assign irq_out = |(st_q.sts & st_q.msk & ~st_q.dir);
  assign soft_irq_out = |(st_q.sts & st_q.msk & st_q.dir);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_value_set_bits: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_VSET
    |=> st_q.outv == ($past(st_q.outv) | $past(bus_req_in.wdata)))
    else $error("value set write lost bits");

  a_value_clear_bits: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_VCLR
    |=> st_q.outv == ($past(st_q.outv) & ~$past(bus_req_in.wdata)))
    else $error("value clear write wrong");

  a_irq_enable_pair: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_IECLR
    ##1 bus_req_in.wr && bus_req_in.addr == `PFG_OFS_IESET
    |=> st_q.ien == (($past(st_q.ien, 2) & ~$past(bus_req_in.wdata, 2))
                     | $past(bus_req_in.wdata)))
    else $error("interrupt enable set or clear wrong");

  a_low_pin_dir: assert property (
    pin_oe_n_out[7:0] == ~$past(st_q.dir[7:0]))
    else $error("low pins do not follow direction");

  a_upper_data_mode: assert property (
    $past(st_q.wide2)
    |-> pin_oe_n_out[15:8] == {8{$past(upper_data_lines_oe_n_in)}}
        && pin_out[15:8] == $past(upper_data_lines_in))
    else $error("upper pins not handed to data bus");

  a_unmapped_read: assert property (
    bus_req_in.rd && bus_req_in.addr > `PFG_OFS_MSK
    |=> rd_data_out == '0 ##1 rd_data_out == '0 || $past(bus_req_in.rd))
    else $error("unmapped read returned data");

  a_input_capture: assert property (
    !st_q.dir[8] |=> flag_status_out[8] == $past(st_q.sync2[8]))
    else $error("input value not captured");

  a_rise_edge_event: assert property (
    !st_q.dir[8] && st_q.ien[8] && st_q.sense[8] && !st_q.pol[8]
    && !st_q.wide2 && $rose(st_q.sync2[8]) |=> st_q.sts[8])
    else $error("rising edge missed");

  a_low_level_event: assert property (
    st_q.dir[0] && st_q.ien[0] && !st_q.sense[0] && st_q.pol[0]
    && !st_q.outv[0] |=> st_q.sts[0])
    else $error("active low level missed");

  a_event_pending: assert property (
    st_q.sts[8] && !(bus_req_in.wr && bus_req_in.addr == `PFG_OFS_STS)
    |=> st_q.sts[8])
    else $error("pending event dropped");

  a_dir_write: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_DIR
    |=> st_q.dir == $past(bus_req_in.wdata))
    else $error("direction write lost");

  a_pol_write: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_POL
    |=> st_q.pol == $past(bus_req_in.wdata))
    else $error("polarity write lost");

  a_sense_write: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_SENSE
    |=> st_q.sense == $past(bus_req_in.wdata))
    else $error("sense type write lost");

  a_edge_write: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_EDGE
    |=> st_q.edge_sel == $past(bus_req_in.wdata))
    else $error("edge select write lost");

  a_mask_write: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_MSK
    |=> st_q.msk == $past(bus_req_in.wdata))
    else $error("mask write lost");

  a_ien_set_bits: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_IESET
    |=> st_q.ien == ($past(st_q.ien) | $past(bus_req_in.wdata)))
    else $error("enable set write wrong");

  a_ien_clear_bits: assert property (
    bus_req_in.wr && bus_req_in.addr == `PFG_OFS_IECLR
    |=> st_q.ien == ($past(st_q.ien) & ~$past(bus_req_in.wdata)))
    else $error("enable clear write wrong");

  a_read_dir_data: assert property (
    bus_req_in.rd && bus_req_in.addr == `PFG_OFS_DIR
    |=> rd_data_out == $past(st_q.dir))
    else $error("direction read wrong");

  a_read_status_data: assert property (
    bus_req_in.rd && bus_req_in.addr == `PFG_OFS_STS
    |=> rd_data_out == $past(st_q.sts))
    else $error("status read wrong");

  a_read_idle_zero: assert property (
    !bus_req_in.rd |=> rd_data_out == '0)
    else $error("read data outside its cycle");

  a_outv_hold: assert property (
    !bus_req_in.wr |=> $stable(st_q.outv))
    else $error("drive value changed without write");

  a_dir_hold: assert property (
    !bus_req_in.wr |=> $stable(st_q.dir))
    else $error("direction changed without write");

  a_ien_hold: assert property (
    !bus_req_in.wr |=> $stable(st_q.ien))
    else $error("enable changed without write");

  a_event_needs_enable: assert property (
    $rose(st_q.sts[8]) |-> $past(st_q.ien[8]))
    else $error("event without enable");

  a_wide_no_event: assert property (
    $rose(st_q.sts[8]) |-> !$past(st_q.wide2))
    else $error("event on pin lent to data bus");

  a_irq_raised: assert property (
    st_q.sts[8] && st_q.msk[8] && !st_q.dir[8] |-> irq_out)
    else $error("hardware interrupt missing");

  a_soft_irq_raised: assert property (
    st_q.sts[0] && st_q.msk[0] && st_q.dir[0] |-> soft_irq_out)
    else $error("software interrupt missing");

  a_irq_quiet: assert property (
    st_q.sts == '0 |-> !irq_out && !soft_irq_out)
    else $error("interrupt without pending event");

  a_output_capture: assert property (
    st_q.dir[0] |=> flag_status_out[0] == $past(st_q.outv[0]))
    else $error("output value not captured");

  a_sync_latency: assert property (
    upper_data_lines_out == $past(pin_in[15:8], 2))
    else $error("pin synchroniser depth wrong");

  a_low_pin_value: assert property (
    pin_out[7:0] == $past(st_q.outv[7:0]))
    else $error("low pins do not follow drive value");

  a_upper_gpio_dir: assert property (
    !$past(st_q.wide2)
    |-> pin_oe_n_out[15:8] == ~$past(st_q.dir[15:8])
        && pin_out[15:8] == $past(st_q.outv[15:8]))
    else $error("upper pins not flags on narrow bus");

  a_single_edge_only: assert property (
    !st_q.dir[8] && st_q.ien[8] && st_q.sense[8] && !st_q.edge_sel[8]
    && !st_q.pol[8] && !st_q.sts[8] && $fell(st_q.sync2[8])
    |=> !st_q.sts[8])
    else $error("falling edge taken in single edge mode");

  a_both_edges_event: assert property (
    !st_q.dir[8] && st_q.ien[8] && st_q.sense[8] && st_q.edge_sel[8]
    && !st_q.pol[8] && !st_q.wide2 && $fell(st_q.sync2[8])
    |=> st_q.sts[8])
    else $error("falling edge missed in dual edge mode");

  a_level_high_event: assert property (
    st_q.dir[0] && st_q.ien[0] && !st_q.sense[0] && !st_q.pol[0]
    && st_q.outv[0] |=> st_q.sts[0])
    else $error("active high level missed");

endmodule : pfg_gpio

/* verilog/pfg_params.svh */
`ifndef PFG_PARAMS_SVH
`define PFG_PARAMS_SVH

`define PFG_NPINS 16
`define PFG_AW 4

// Register offsets on the plain port
`define PFG_OFS_DIR 4'h0
`define PFG_OFS_VSET 4'h1
`define PFG_OFS_VCLR 4'h2
`define PFG_OFS_IESET 4'h3
`define PFG_OFS_IECLR 4'h4
`define PFG_OFS_POL 4'h5
`define PFG_OFS_SENSE 4'h6
`define PFG_OFS_EDGE 4'h7
`define PFG_OFS_STS 4'h8
`define PFG_OFS_MSK 4'h9

// Pins always usable as flags whatever the bus width
`define PFG_LOW_PINS 16'h00ff

// Reset values
`define PFG_RST_DIR 16'h0000
`define PFG_RST_OUTV 16'h0000
`define PFG_RST_IEN 16'h0000
`define PFG_RST_POL 16'h0000
`define PFG_RST_SENSE 16'h0000
`define PFG_RST_EDGE 16'h0000
`define PFG_RST_STS 16'h0000
`define PFG_RST_MSK 16'h0000
`define PFG_RST_OE_N 16'hffff

`endif

/* verilog/pfg_pkg.sv */
`include "pfg_params.svh"

package pfg_pkg;

  typedef logic [`PFG_NPINS-1:0] pfg_word_t;

  typedef struct packed {
    logic [`PFG_AW-1:0] addr;
    pfg_word_t wdata;
    logic wr;
    logic rd;
  } pfg_bus_req_t;

  typedef struct packed {
    pfg_word_t dir;
    pfg_word_t outv;
    pfg_word_t ien;
    pfg_word_t pol;
    pfg_word_t sense;
    pfg_word_t edge_sel;
    pfg_word_t sts;
    pfg_word_t msk;
    pfg_word_t sync1;
    pfg_word_t sync2;
    pfg_word_t prev;
    pfg_word_t flags;
    pfg_word_t rdata;
    pfg_word_t pin_o;
    pfg_word_t pin_oe_n;
    logic wide1;
    logic wide2;
  } pfg_state_t;

endpackage : pfg_pkg
